// ### src/charger_status_readback.sv
// Behaviour
// - Live bit 6 shows the constant-voltage taper phase.
// - Live bit 5 shows charge complete.
// - Live bit 4 shows input current limiting.
// - Live bit 3 shows power-path reduction of charge current.
// - Live bit 2 shows input voltage regulation.
// - Live bit 1 shows die thermal throttling.
// - Live bit 0 shows input supply good (above UVLO, sleep, below OVP).
// - Fault bit 7 shows input overvoltage.
// - Fault bit 5 shows battery overcurrent protection.
// - Fault bit 4 shows battery below lockout level.
// - Fault bit 2 shows thermistor cool zone.
// - Fault bit 1 shows thermistor warm zone.
// - Live status register is read-only at offset 0x0.
// - Fault register is read-only at offset 0x1, bit 6 reserved.
// - Flag register at 0x3 latches live events, cleared when read.
module charger_status_readback (
    input wire logic clk_sys, // System clock, 50 MHz
    input wire logic rstn, // Async reset, active low
    input wire logic [7:0] regAddr, // Register offset
    input wire logic regRead, // Read strobe, one cycle
    input wire logic regWrite, // Write strobe, one cycle
    input wire logic [7:0] regWdata, // Write data, ignored
    output logic [7:0] regRdata, // Read data, valid cycle after read
    input wire logic taper_phase_active, // Comparator: CV phase
    input wire logic charge_done, // Comparator: termination
    input wire logic input_current_limiting, // Comparator: ILIM loop
    input wire logic power_path_reduction_active, // Comparator: power path
    input wire logic input_voltage_regulation_active, // Comparator: VIN reg
    input wire logic die_thermal_throttle_active, // Comparator: thermal
    input wire logic input_supply_good, // Comparator: supply good
    input wire logic input_overvoltage_active, // Comparator: VIN OVP
    input wire logic battery_overcurrent_active, // Comparator: bat OCP
    input wire logic battery_undervoltage_active, // Comparator: bat UVLO
    input wire logic thermistor_cold_zone, // Comparator: cold
    input wire logic thermistor_cool_zone, // Comparator: cool
    input wire logic thermistor_warm_zone, // Comparator: warm
    input wire logic thermistor_hot_zone // Comparator: hot
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [13:0] rawIn;
    logic [13:0] syncA;
    logic [13:0] syncB;
    logic [13:0] syncC;
    logic [13:0] stable;
    logic [13:0] next_stable;

    assign rawIn = {
        input_overvoltage_active, battery_overcurrent_active,
        battery_undervoltage_active, thermistor_cold_zone,
        thermistor_cool_zone, thermistor_warm_zone, thermistor_hot_zone,
        taper_phase_active, charge_done, input_current_limiting,
        power_path_reduction_active, input_voltage_regulation_active,
        die_thermal_throttle_active, input_supply_good};

    // A change is accepted only once the last two stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 14; gi++) begin : g_sync
            always_comb begin
                next_stable[gi] = (syncB[gi] == syncC[gi]) ? syncC[gi]
                                                           : stable[gi];
            end
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    syncA[gi] <= 1'b0;
                    syncB[gi] <= 1'b0;
                    syncC[gi] <= 1'b0;
                    stable[gi] <= 1'b0;
                end else begin
                    syncA[gi] <= rawIn[gi];
                    syncB[gi] <= syncA[gi];
                    syncC[gi] <= syncB[gi];
                    stable[gi] <= next_stable[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // Live register images
    // ****************************************
    logic [7:0] liveStatus;
    logic [7:0] faultStatus;

    always_comb begin
        liveStatus = 8'h00;
        liveStatus[charger_status_pkg::TAPER_BIT] = stable[6];
        liveStatus[charger_status_pkg::DONE_BIT] = stable[5];
        liveStatus[charger_status_pkg::ILIM_BIT] = stable[4];
        liveStatus[charger_status_pkg::PPATH_BIT] = stable[3];
        liveStatus[charger_status_pkg::VREG_BIT] = stable[2];
        liveStatus[charger_status_pkg::THERM_BIT] = stable[1];
        liveStatus[charger_status_pkg::SUPPLY_GOOD_BIT] = stable[0];
        faultStatus = 8'h00;
        faultStatus[charger_status_pkg::OVP_BIT] = stable[13];
        faultStatus[charger_status_pkg::OCP_BIT] = stable[12];
        faultStatus[charger_status_pkg::UVLO_BIT] = stable[11];
        faultStatus[charger_status_pkg::COLD_BIT] = stable[10];
        faultStatus[charger_status_pkg::COOL_BIT] = stable[9];
        faultStatus[charger_status_pkg::WARM_BIT] = stable[8];
        faultStatus[charger_status_pkg::HOT_BIT] = stable[7];
    end

    // ****************************************
    // Event flags and read port
    // ****************************************
    logic [6:0] prevLive;
    logic [7:0] eventFlags;
    logic [7:0] next_eventFlags;
    logic [7:0] next_regRdata;
    logic [7:0] newEvents;
    logic flagRead;

    assign flagRead = regRead
        && (regAddr == charger_status_pkg::EVENT_FLAG_OFS);

    always_comb begin
        // Conditions flag on entry; supply good flags on any change
        newEvents = {1'b0, liveStatus[6:1] & ~prevLive[6:1],
                     liveStatus[0] ^ prevLive[0]};
        // An event in the reading cycle survives into the next read
        next_eventFlags = (flagRead ? charger_status_pkg::FLAG_RESET
                                    : eventFlags) | newEvents;
        next_regRdata = regRdata;
        if (regRead) begin
            case (regAddr)
                charger_status_pkg::LIVE_STATUS_OFS: begin
                    next_regRdata = liveStatus
                        & charger_status_pkg::LIVE_USED_MASK;
                end
                charger_status_pkg::FAULT_TEMP_OFS: begin
                    next_regRdata = faultStatus
                        & charger_status_pkg::FAULT_USED_MASK;
                end
                charger_status_pkg::EVENT_FLAG_OFS: begin
                    next_regRdata = eventFlags;
                end
                default: begin
                    next_regRdata = 8'h00;
                end
            endcase
        end
    end

    // Writes never reach any state here, so all offsets stay read-only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prevLive <= 7'h00;
            eventFlags <= charger_status_pkg::FLAG_RESET;
            regRdata <= charger_status_pkg::DATA_RESET;
        end else begin
            prevLive <= liveStatus[6:0];
            eventFlags <= next_eventFlags;
            regRdata <= next_regRdata;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking checkClk @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence liveRead;
        regRead && regAddr == charger_status_pkg::LIVE_STATUS_OFS;
    endsequence
    sequence faultRead;
        regRead && regAddr == charger_status_pkg::FAULT_TEMP_OFS;
    endsequence
    // Entry into taper, then a cycle with no clearing read
    sequence taperEntry;
        $rose(stable[6]) ##1 !flagRead;
    endsequence

    taper_read_a: assert property (liveRead |=>
        regRdata[6] == $past(stable[6]))
        else $error("taper bit mismatch");
    done_read_a: assert property (liveRead |=>
        regRdata[5] == $past(charge_done, 4)
            || $past(syncB[5], 2) != $past(syncC[5], 2)
            || $past(syncB[5]) != $past(syncC[5]))
        else $error("charge done bit mismatch");
    limit_bits_a: assert property (liveRead |=>
        regRdata[4:1] == $past(stable[4:1]))
        else $error("regulation bits mismatch");
    supply_good_a: assert property (liveRead |=>
        regRdata[0] == $past(stable[0]))
        else $error("supply good bit mismatch");
    overvolt_read_a: assert property (faultRead |=>
        regRdata[7] == $past(stable[13]))
        else $error("overvoltage bit mismatch");
    battery_fault_a: assert property (faultRead |=>
        regRdata[5:4] == $past(stable[12:11]))
        else $error("battery fault bits mismatch");
    thermistor_read_a: assert property (faultRead |=>
        regRdata[3:0] == $past(stable[10:7]))
        else $error("thermistor zone bits mismatch");
    reserved_zero_a: assert property (liveRead |=> !regRdata[7])
        else $error("live reserved bit set");
    fault_reserved_a: assert property (faultRead |=> !regRdata[6])
        else $error("fault reserved bit set");
    flag_read_a: assert property (flagRead |=>
        regRdata == $past(eventFlags))
        else $error("flag read data mismatch");
    flag_clear_a: assert property (
        flagRead && newEvents == 8'h00 |=> eventFlags == 8'h00)
        else $error("flags not cleared on read");
    event_set_a: assert property (taperEntry |=> eventFlags[6])
        else $error("taper entry not flagged");
    write_ignored_a: assert property (
        regWrite && !regRead |=> $stable(regRdata))
        else $error("write disturbed read data");
    filter_hold_a: assert property (
        syncB[0] != syncC[0] |=> $stable(stable[0]))
        else $error("unconfirmed change accepted");
endmodule

// ### src/charger_status_pkg.sv
package charger_status_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] LIVE_STATUS_OFS = 8'h00;
    localparam logic [7:0] FAULT_TEMP_OFS = 8'h01;
    localparam logic [7:0] EVENT_FLAG_OFS = 8'h03;

    // ****************************************
    // Field positions, live status register
    // ****************************************
    localparam int TAPER_BIT = 6;
    localparam int DONE_BIT = 5;
    localparam int ILIM_BIT = 4;
    localparam int PPATH_BIT = 3;
    localparam int VREG_BIT = 2;
    localparam int THERM_BIT = 1;
    localparam int SUPPLY_GOOD_BIT = 0;

    // ****************************************
    // Field positions, fault and temperature register
    // ****************************************
    localparam int OVP_BIT = 7;
    localparam int OCP_BIT = 5;
    localparam int UVLO_BIT = 4;
    localparam int COLD_BIT = 3;
    localparam int COOL_BIT = 2;
    localparam int WARM_BIT = 1;
    localparam int HOT_BIT = 0;

    // ****************************************
    // Reserved masks and reset values
    // ****************************************
    localparam logic [7:0] LIVE_USED_MASK = 8'h7F;
    localparam logic [7:0] FAULT_USED_MASK = 8'hBF;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
endpackage

// ### sim/comparator_bank.sv
module comparator_bank (
    input wire logic clk_sys, // Sampling clock
    input wire logic [13:0] target, // Conditions set by the bench
    output logic [13:0] levels // Comparator levels, taper first
);
    timeunit 1ns;
    timeprecision 1ps;
    initial levels = 14'h0000;
    // Levels move just after the edge, so no input changes on a sample
    always @(posedge clk_sys) levels <= #1 target;
endmodule

// ### sim/charger_status_readback_test.sv
module charger_status_readback_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic regRead = 1'b0;
    logic regWrite = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic [13:0] target = 14'h0000;
    logic [13:0] lv;
    logic pend = 1'b0;
    logic [7:0] expQ[$];
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    comparator_bank bank (.clk_sys(clk_sys), .target(target), .levels(lv));
    charger_status_readback DUT (
        .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
        .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata),
        .regRdata(regRdata), .taper_phase_active(lv[13]),
        .charge_done(lv[12]), .input_current_limiting(lv[11]),
        .power_path_reduction_active(lv[10]),
        .input_voltage_regulation_active(lv[9]),
        .die_thermal_throttle_active(lv[8]), .input_supply_good(lv[7]),
        .input_overvoltage_active(lv[6]),
        .battery_overcurrent_active(lv[5]),
        .battery_undervoltage_active(lv[4]),
        .thermistor_cold_zone(lv[3]), .thermistor_cool_zone(lv[2]),
        .thermistor_warm_zone(lv[1]), .thermistor_hot_zone(lv[0]));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error regRdata expected %h seen %h", exp, seen);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reads are held high across edges so back-to-back reads never
    // assign the strobe twice in one step
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys) #1;
        regRead = 1'b1;
        regAddr = a;
        expQ.push_back(e);
    endtask
    task automatic settle(input logic [13:0] t);
        @(posedge clk_sys) #1;
        regRead = 1'b0;
        target = t;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge clk_sys) #1;
        regWrite = 1'b0;
    endtask
    // ****************************************
    // Clock, watcher, timeout
    // ****************************************
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) pend <= regRead;
    always @(negedge clk_sys) begin
        if (pend) check(regRdata, expQ.pop_front());
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            close_out();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [13:0] v;
        void'($urandom(9));
        repeat (3) @(posedge clk_sys);
        #1 rstn = 1'b1;
        rd(8'h03, 8'h00);
        settle(14'h3F80);
        rd(8'h03, 8'h7F);
        rd(8'h03, 8'h00);
        settle(14'h3F00);
        rd(8'h03, 8'h01);
        rd(8'h00, 8'h7E);
        for (int i = 0; i < 24; i++) begin
            v = 14'($urandom);
            settle(v);
            wr(8'($urandom % 2), 8'($urandom));
            rd(8'h00, {1'b0, v[13:7]});
            rd(8'h01, {v[6], 1'b0, v[5:0]});
            rd(8'h00, {1'b0, v[13:7]});
            rd(8'h01, {v[6], 1'b0, v[5:0]});
            rd(8'(4 + $urandom % 252), 8'h00);
            rd(8'h02, 8'h00);
        end
        @(posedge clk_sys) #1;
        regRead = 1'b0;
        repeat (3) @(posedge clk_sys);
        close_out();
    end
endmodule
